// File: logic/pmcr_regs.sv
// port mode configuration register bank with apb access
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

// Overview of operation
// - Bits 2:0 of the parallel mode register pick printer (reset), standard, EPP, ECP and combined modes.
// - Bits 6:3 of the parallel mode register hold the ECP FIFO threshold, reset to 0111.
// - Interrupt type one gives a low pulse then release, zero makes it follow the request or a level.
// - The interrupt type bit is ignored in printer and standard modes.
// - The drive mux field gives normal port, drive 0 on floppy pins and drive 1 on port pins, or both on port pins.
// - Bit 0 of each UART mode register enables MIDI support, off at reset.
// - Bit 1 of each UART mode register enables the high-speed option, off at reset.
// - Bit 7 of the first UART mode register makes both UARTs drive a common interrupt.
// - With sharing on, an interrupt from either UART asserts both UART interrupt pins.
// - Infrared receive polarity is bit 0 (low at reset) and transmit polarity bit 1 (high at reset).
// - Bit 2 of the infrared option chooses full duplex (reset) or half duplex.
// - Bits 5:3 pick the infrared mode: standard at 000, IrDA at 001, 011 reserved.
// - Bit 6 routes infrared over the second UART pins (reset) or the alternate infrared pins.
// - The turnaround register blanks receive after transmit in 100 us steps, zero only during transmit.
// - The registers reset only on hard reset and ignore soft resets.
module pmcr_regs
    import pmcr_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // event interrupt
    output logic             irq,
    // parallel port core
    output logic [2:0]       pp_mode,
    output logic [3:0]       pp_fifo_threshold,
    input  wire logic        pp_irq_request,
    output logic             pp_irq_out,
    output logic             pp_irq_oe,
    // floppy drive mux
    output logic             split_drive_mux,
    output logic             all_drives_on_port_pins,
    // uart cores
    output logic [1:0]       uart_midi_enable,
    output logic [1:0]       uart_high_speed,
    input  wire logic [1:0]  uart_irq_request,
    output logic [1:0]       uart_irq_out,
    // infrared core
    output logic [2:0]       ir_mode,
    output logic             ir_half_duplex,
    input  wire logic        ir_tx_data,
    input  wire logic        ir_tx_busy,
    output logic             ir_rx_data,
    // infrared pins
    input  wire logic        second_uart_receive_pin,
    input  wire logic        alt_infrared_receive_pin,
    output logic             second_uart_transmit_pin,
    output logic             alt_infrared_transmit_pin
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  pp_mode_r;
        logic [7:0]  pp_mux_r;
        logic [7:0]  u1_mode_r;
        logic [7:0]  u2_mode_r;
        logic [7:0]  ir_opt_r;
        logic [7:0]  ir_to_r;
        logic [1:0]  ev_status;
        logic [1:0]  ev_mask;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        irq;
        logic [1:0]  rx_sync1;
        logic [1:0]  rx_sync2;
        logic        rx_prev;
        logic        pp_req_prev;
        logic        pp_irq_out;
        logic        pp_irq_oe;
        logic [1:0]  uart_irq_out;
        logic        ir_rx_data;
        logic        tx_second;
        logic        tx_alt;
    } pmcr_state_t;

    pmcr_state_t st;
    pmcr_state_t next_st;
    logic        blank;
    logic        blank_done;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic [3:0] pmcr_decode(input logic [11:0] addr);
        case (addr)
            ADDR_PP_MODE:    pmcr_decode = 4'h1;
            ADDR_PP_MUX:     pmcr_decode = 4'h2;
            ADDR_U1_MODE:    pmcr_decode = 4'h3;
            ADDR_U2_MODE:    pmcr_decode = 4'h4;
            ADDR_IR_OPTION:  pmcr_decode = 4'h5;
            ADDR_IR_TIMEOUT: pmcr_decode = 4'h6;
            ADDR_EV_STATUS:  pmcr_decode = 4'h7;
            ADDR_EV_MASK:    pmcr_decode = 4'h8;
            default:         pmcr_decode = 4'h0;
        endcase
    endfunction

    function automatic logic [7:0] pmcr_merge(input logic [7:0] old, input logic [7:0] wdata,
                                              input logic [7:0] wmask);
        pmcr_merge = (old & ~wmask) | (wdata & wmask);
    endfunction

    // ------------------------------------------------------------
    // half duplex blanking
    // ------------------------------------------------------------
    pmcr_blank_timer u_blank (
        .pclk      (pclk),
        .presetn   (presetn),
        .tx_active (ir_tx_busy & st.ir_opt_r[IR_HALF]),
        .timeout   (st.ir_to_r),
        .blank     (blank),
        .done      (blank_done)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] sel;
        logic       wr;
        logic [2:0] mode;
        logic [1:0] ev_set;
        logic       rx_pin;
        logic       rx_logic;
        logic       tx_pin;
        logic       pp_irq_typed;
        sel          = pmcr_decode(paddr);
        wr           = psel & penable & st.pready & pwrite;
        mode         = st.pp_mode_r[PP_MODE_LSB +: 3];
        ev_set       = 2'h0;
        rx_pin       = 1'b0;
        rx_logic     = 1'b0;
        tx_pin       = 1'b0;
        pp_irq_typed = 1'b0;
        next_st      = st;

        // apb: one wait cycle, answer in the second access cycle
        next_st.pready  = psel & penable & ~st.pready;
        next_st.pslverr = psel & penable & ~st.pready & (sel == 4'h0);
        next_st.prdata  = 32'h0000_0000;
        if (psel & penable & ~st.pready & ~pwrite) begin
            case (sel)
                4'h1:    next_st.prdata = {24'h000000, st.pp_mode_r};
                4'h2:    next_st.prdata = {24'h000000, st.pp_mux_r};
                4'h3:    next_st.prdata = {24'h000000, st.u1_mode_r};
                4'h4:    next_st.prdata = {24'h000000, st.u2_mode_r};
                4'h5:    next_st.prdata = {24'h000000, st.ir_opt_r};
                4'h6:    next_st.prdata = {24'h000000, st.ir_to_r};
                4'h7:    next_st.prdata = {30'h00000000, st.ev_status};
                4'h8:    next_st.prdata = {30'h00000000, st.ev_mask};
                default: next_st.prdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (sel)
                4'h1:    next_st.pp_mode_r = pmcr_merge(st.pp_mode_r, pwdata[7:0], WM_PP_MODE);
                4'h2:    next_st.pp_mux_r  = pmcr_merge(st.pp_mux_r, pwdata[7:0], WM_PP_MUX);
                4'h3:    next_st.u1_mode_r = pmcr_merge(st.u1_mode_r, pwdata[7:0], WM_U1_MODE);
                4'h4:    next_st.u2_mode_r = pmcr_merge(st.u2_mode_r, pwdata[7:0], WM_U2_MODE);
                4'h5:    next_st.ir_opt_r  = pmcr_merge(st.ir_opt_r, pwdata[7:0], WM_IR_OPTION);
                4'h6:    next_st.ir_to_r   = pmcr_merge(st.ir_to_r, pwdata[7:0], WM_IR_TIMEOUT);
                4'h8:    next_st.ev_mask   = pwdata[1:0];
                default: next_st.ev_mask   = st.ev_mask;
            endcase
        end

        // infrared receive path: synchronise, pick location, fix polarity, blank
        next_st.rx_sync1 = {alt_infrared_receive_pin, second_uart_receive_pin};
        next_st.rx_sync2 = st.rx_sync1;
        rx_pin           = st.ir_opt_r[IR_ALT_PINS] ? st.rx_sync2[1] : st.rx_sync2[0];
        rx_logic         = rx_pin ^ st.ir_opt_r[IR_RX_POL];
        next_st.rx_prev  = rx_logic;
        next_st.ir_rx_data = rx_logic & ~blank;

        // infrared transmit path, idle line sits at the inactive level
        tx_pin            = ir_tx_data ^ st.ir_opt_r[IR_TX_POL];
        next_st.tx_second = st.ir_opt_r[IR_ALT_PINS] ? ~st.ir_opt_r[IR_TX_POL] : tx_pin;
        next_st.tx_alt    = st.ir_opt_r[IR_ALT_PINS] ? tx_pin : ~st.ir_opt_r[IR_TX_POL];

        // uart interrupt routing
        if (st.u1_mode_r[U_SHARE_IRQ]) begin
            next_st.uart_irq_out = {2{|uart_irq_request}};
        end else begin
            next_st.uart_irq_out = uart_irq_request;
        end

        // parallel port interrupt pin
        next_st.pp_req_prev = pp_irq_request;
        pp_irq_typed = st.pp_mode_r[PP_IRQ_TYPE] & (mode != PPM_PRINTER) & (mode != PPM_SPP);
        if (pp_irq_typed) begin
            next_st.pp_irq_out = 1'b0;
            next_st.pp_irq_oe  = pp_irq_request & ~st.pp_req_prev;
        end else begin
            next_st.pp_irq_out = pp_irq_request;
            next_st.pp_irq_oe  = 1'b1;
        end

        // events: set wins over write-one-to-clear
        ev_set[EV_BLANK_DONE] = blank_done;
        ev_set[EV_RX_EDGE]    = rx_logic ^ st.rx_prev;
        if (wr && sel == 4'h7) begin
            next_st.ev_status = (st.ev_status & ~pwdata[1:0]) | ev_set;
        end else begin
            next_st.ev_status = st.ev_status | ev_set;
        end
        next_st.irq = |(next_st.ev_status & next_st.ev_mask);
    end

    // ------------------------------------------------------------
    // state register, hard reset only
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st           <= '0;
            st.pp_mode_r <= RST_PP_MODE;
            st.pp_mux_r  <= RST_PP_MUX;
            st.u1_mode_r <= RST_U1_MODE;
            st.u2_mode_r <= RST_U2_MODE;
            st.ir_opt_r  <= RST_IR_OPTION;
            st.ir_to_r   <= RST_IR_TIMEOUT;
            st.tx_second <= 1'b0;
            st.tx_alt    <= 1'b0;
            st.pp_irq_oe <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pready                    = st.pready;
    assign prdata                    = st.prdata;
    assign pslverr                   = st.pslverr;
    assign irq                       = st.irq;
    assign pp_mode                   = st.pp_mode_r[PP_MODE_LSB +: 3];
    assign pp_fifo_threshold         = st.pp_mode_r[PP_THR_LSB +: 4];
    assign pp_irq_out                = st.pp_irq_out;
    assign pp_irq_oe                 = st.pp_irq_oe;
    assign split_drive_mux           = (st.pp_mux_r[1:0] == MUX_SPLIT);
    assign all_drives_on_port_pins   = (st.pp_mux_r[1:0] == MUX_ALL);
    assign uart_midi_enable          = {st.u2_mode_r[U_MIDI], st.u1_mode_r[U_MIDI]};
    assign uart_high_speed           = {st.u2_mode_r[U_HIGH_SPEED], st.u1_mode_r[U_HIGH_SPEED]};
    assign uart_irq_out              = st.uart_irq_out;
    assign ir_mode                   = st.ir_opt_r[IR_MODE_LSB +: 3];
    assign ir_half_duplex            = st.ir_opt_r[IR_HALF];
    assign ir_rx_data                = st.ir_rx_data;
    assign second_uart_transmit_pin  = st.tx_second;
    assign alt_infrared_transmit_pin = st.tx_alt;
endmodule

// File: include/pmcr_pkg.sv
// constants of the port mode configuration register bank
package pmcr_pkg;
    // ------------------------------------------------------------
    // register indices and logical device bases
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_MODE        = 8'hf0;
    localparam logic [7:0]  IDX_OPTION      = 8'hf1;
    localparam logic [7:0]  IDX_TIMEOUT     = 8'hf2;
    localparam logic [11:0] BASE_PARALLEL   = 12'h000;
    localparam logic [11:0] BASE_UART_ONE   = 12'h400;
    localparam logic [11:0] BASE_UART_TWO   = 12'h800;
    localparam logic [11:0] BASE_EVENTS     = 12'hc00;
    localparam logic [11:0] ADDR_PP_MODE    = BASE_PARALLEL + {2'h0, IDX_MODE, 2'h0};
    localparam logic [11:0] ADDR_PP_MUX     = BASE_PARALLEL + {2'h0, IDX_OPTION, 2'h0};
    localparam logic [11:0] ADDR_U1_MODE    = BASE_UART_ONE + {2'h0, IDX_MODE, 2'h0};
    localparam logic [11:0] ADDR_U2_MODE    = BASE_UART_TWO + {2'h0, IDX_MODE, 2'h0};
    localparam logic [11:0] ADDR_IR_OPTION  = BASE_UART_TWO + {2'h0, IDX_OPTION, 2'h0};
    localparam logic [11:0] ADDR_IR_TIMEOUT = BASE_UART_TWO + {2'h0, IDX_TIMEOUT, 2'h0};
    localparam logic [11:0] ADDR_EV_STATUS  = BASE_EVENTS + 12'h000;
    localparam logic [11:0] ADDR_EV_MASK    = BASE_EVENTS + 12'h004;

    // ------------------------------------------------------------
    // reset values and writable bits
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PP_MODE    = 8'h3c;
    localparam logic [7:0] RST_PP_MUX     = 8'h00;
    localparam logic [7:0] RST_U1_MODE    = 8'h00;
    localparam logic [7:0] RST_U2_MODE    = 8'h00;
    localparam logic [7:0] RST_IR_OPTION  = 8'h02;
    localparam logic [7:0] RST_IR_TIMEOUT = 8'h03;
    localparam logic [7:0] WM_PP_MODE     = 8'hff;
    localparam logic [7:0] WM_PP_MUX      = 8'h03;
    localparam logic [7:0] WM_U1_MODE     = 8'h83;
    localparam logic [7:0] WM_U2_MODE     = 8'h03;
    localparam logic [7:0] WM_IR_OPTION   = 8'h7f;
    localparam logic [7:0] WM_IR_TIMEOUT  = 8'hff;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PP_MODE_LSB   = 0;
    localparam int PP_THR_LSB    = 3;
    localparam int PP_IRQ_TYPE   = 7;
    localparam int U_MIDI        = 0;
    localparam int U_HIGH_SPEED  = 1;
    localparam int U_SHARE_IRQ   = 7;
    localparam int IR_RX_POL     = 0;
    localparam int IR_TX_POL     = 1;
    localparam int IR_HALF       = 2;
    localparam int IR_MODE_LSB   = 3;
    localparam int IR_ALT_PINS   = 6;
    localparam int EV_BLANK_DONE = 0;
    localparam int EV_RX_EDGE    = 1;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [2:0] PPM_PRINTER  = 3'h4;
    localparam logic [2:0] PPM_SPP      = 3'h0;
    localparam logic [2:0] PPM_EPP19    = 3'h1;
    localparam logic [2:0] PPM_EPP17    = 3'h5;
    localparam logic [2:0] PPM_ECP      = 3'h2;
    localparam logic [2:0] PPM_ECP_E19  = 3'h3;
    localparam logic [2:0] PPM_ECP_E17  = 3'h7;
    localparam logic [1:0] MUX_NORMAL   = 2'h0;
    localparam logic [1:0] MUX_SPLIT    = 2'h1;
    localparam logic [1:0] MUX_ALL      = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ      = 20000;
    localparam int STEP_US      = 100;
    localparam int STEP_CYCLES  = (STEP_US * CLK_KHZ) / 1000;
    localparam logic [10:0] STEP_LAST = 11'(STEP_CYCLES - 1);
endpackage

// File: logic/pmcr_blank_timer.sv
// receive blanking timer for half duplex infrared
`timescale 1ns/1ps
module pmcr_blank_timer
    import pmcr_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control
    input  wire logic       tx_active,
    input  wire logic [7:0] timeout,
    // status
    output logic            blank,
    output logic            done
);
    typedef struct packed {
        logic [7:0]  steps;
        logic [10:0] cycles;
        logic        blank;
        logic        done;
    } pmcr_tmr_t;

    pmcr_tmr_t st;
    pmcr_tmr_t next_st;

    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (tx_active) begin
            next_st.blank  = 1'b1;
            next_st.steps  = timeout;
            next_st.cycles = 11'h000;
        end else if (st.blank) begin
            if (st.steps == 8'h00) begin
                next_st.blank = 1'b0;
                next_st.done  = 1'b1;
            end else if (st.cycles == STEP_LAST) begin
                next_st.cycles = 11'h000;
                next_st.steps  = st.steps - 8'h01;
            end else begin
                next_st.cycles = st.cycles + 11'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign blank = st.blank;
    assign done  = st.done;
endmodule

// File: verification/pmcr_regs_properties.sv
// concurrent checks on the ports of the port mode register bank
`timescale 1ns/1ps
module pmcr_regs_checker (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // parallel port and mux
    input wire logic [2:0]  pp_mode,
    input wire logic        pp_irq_request,
    input wire logic        pp_irq_out,
    input wire logic        pp_irq_oe,
    input wire logic        split_drive_mux,
    input wire logic        all_drives_on_port_pins,
    // uart and infrared
    input wire logic [1:0]  uart_irq_request,
    input wire logic [1:0]  uart_irq_out,
    input wire logic        ir_half_duplex,
    input wire logic        ir_tx_busy,
    input wire logic        ir_rx_data
);
    import pmcr_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer missing");
    apb_single_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    unmapped_err_a: assert property (pready && paddr == 12'h100 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mux_exclusive_a: assert property (!(split_drive_mux && all_drives_on_port_pins))
        else $error("both mux outputs set");
    uart_quiet_a: assert property (uart_irq_request == 2'h0 |=> uart_irq_out == 2'h0)
        else $error("uart interrupt without request");
    uart_one_a: assert property (uart_irq_request[0] |=> uart_irq_out[0])
        else $error("uart one interrupt lost");
    uart_two_a: assert property (uart_irq_request[1] |=> uart_irq_out[1])
        else $error("uart two interrupt lost");
    pp_type_ignored_a: assert property ((pp_mode == PPM_PRINTER || pp_mode == PPM_SPP) && $stable(pp_mode)
        |=> pp_irq_oe && pp_irq_out == $past(pp_irq_request)) else $error("interrupt type used in plain mode");
    rx_blanked_a: assert property ((ir_half_duplex && ir_tx_busy) [*4] |-> !ir_rx_data)
        else $error("receive not blanked during transmit");
endmodule

bind pmcr_regs pmcr_regs_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pp_mode(pp_mode), .pp_irq_request(pp_irq_request),
    .pp_irq_out(pp_irq_out), .pp_irq_oe(pp_irq_oe), .split_drive_mux(split_drive_mux),
    .all_drives_on_port_pins(all_drives_on_port_pins), .uart_irq_request(uart_irq_request),
    .uart_irq_out(uart_irq_out), .ir_half_duplex(ir_half_duplex), .ir_tx_busy(ir_tx_busy),
    .ir_rx_data(ir_rx_data)
);

// File: verification/pmcr_regs_bench.sv
// self-checking bench for the port mode register bank
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module pmcr_regs_bench;
    import pmcr_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic        pp_irq_request = 1'b0;
    logic [1:0]  uart_irq_request = 2'h0;
    logic        ir_tx_data = 1'b0;
    logic        ir_tx_busy = 1'b0;
    logic        second_uart_receive_pin = 1'b0;
    logic        alt_infrared_receive_pin = 1'b0;
    logic        pready, pslverr, irq, pp_irq_out, pp_irq_oe, split_drive_mux, all_drives_on_port_pins;
    logic        ir_half_duplex, ir_rx_data, second_uart_transmit_pin, alt_infrared_transmit_pin, rerr;
    logic [31:0] prdata, rdata;
    logic [2:0]  pp_mode, ir_mode;
    logic [3:0]  pp_fifo_threshold;
    logic [1:0]  uart_midi_enable, uart_high_speed, uart_irq_out;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [11:0] addrs [6] = '{ADDR_PP_MODE, ADDR_PP_MUX, ADDR_U1_MODE, ADDR_U2_MODE, ADDR_IR_OPTION, ADDR_IR_TIMEOUT};
    logic [7:0]  rsts [6]  = '{RST_PP_MODE, RST_PP_MUX, RST_U1_MODE, RST_U2_MODE, RST_IR_OPTION, RST_IR_TIMEOUT};
    logic [7:0]  masks [6] = '{WM_PP_MODE, WM_PP_MUX, WM_U1_MODE, WM_U2_MODE, WM_IR_OPTION, WM_IR_TIMEOUT};
    logic [2:0]  modes [7] = '{PPM_PRINTER, PPM_SPP, PPM_EPP19, PPM_EPP17, PPM_ECP, PPM_ECP_E19, PPM_ECP_E17};

    pmcr_regs uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .pp_mode(pp_mode),
        .pp_fifo_threshold(pp_fifo_threshold), .pp_irq_request(pp_irq_request), .pp_irq_out(pp_irq_out),
        .pp_irq_oe(pp_irq_oe), .split_drive_mux(split_drive_mux), .all_drives_on_port_pins(all_drives_on_port_pins),
        .uart_midi_enable(uart_midi_enable), .uart_high_speed(uart_high_speed), .uart_irq_request(uart_irq_request),
        .uart_irq_out(uart_irq_out), .ir_mode(ir_mode), .ir_half_duplex(ir_half_duplex), .ir_tx_data(ir_tx_data),
        .ir_tx_busy(ir_tx_busy), .ir_rx_data(ir_rx_data), .second_uart_receive_pin(second_uart_receive_pin),
        .alt_infrared_receive_pin(alt_infrared_receive_pin), .second_uart_transmit_pin(second_uart_transmit_pin),
        .alt_infrared_transmit_pin(alt_infrared_transmit_pin)
    );

    // ------------------------------------------------------------
    // clock, watchdog, bus tasks and expectations
    // ------------------------------------------------------------
    always #25 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        `CHK(n < 16, 1'b1)
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(negedge pclk);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask

    task automatic check_resets();
        for (int i = 0; i < 6; i++) rd_chk(addrs[i], {24'h0, rsts[i]});
    endtask

    function automatic logic [1:0] exp_uart(input logic [1:0] r, input logic sh);
        return sh ? {2{|r}} : r;
    endfunction

    // pulse type drives low once and lets go, other types follow the request
    task automatic pulse_pp(input logic pulsed);
        @(posedge pclk);
        pp_irq_request <= 1'b1;
        repeat (2) @(negedge pclk);
        `CHK({pp_irq_oe, pp_irq_out}, pulsed ? 2'b10 : 2'b11)
        @(negedge pclk);
        `CHK({pp_irq_oe, pp_irq_out}, pulsed ? 2'b00 : 2'b11)
        @(posedge pclk);
        pp_irq_request <= 1'b0;
        repeat (2) @(negedge pclk);
        `CHK({pp_irq_oe, pp_irq_out}, pulsed ? 2'b00 : 2'b10)
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v, b;
        logic       d;
        void'($urandom(29));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        check_resets();
        repeat (4) for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            apb(1'b1, addrs[i], {24'($urandom), v});
            rd_chk(addrs[i], {24'h0, v & masks[i]});
        end
        apb(1'b1, 12'h100, 32'hffff_ffff);
        `CHK(rerr, 1'b1)
        rd_chk(12'h100, 32'h0);
        $display("test reset and access done");
        for (int i = 0; i < 7; i++) begin
            v = {1'b0, 4'($urandom), modes[i]};
            wr(ADDR_PP_MODE, {24'h0, v});
            `CHK({pp_fifo_threshold, pp_mode}, v[6:0])
        end
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_PP_MUX, 32'(i));
            `CHK({all_drives_on_port_pins, split_drive_mux}, 2'(i))
        end
        wr(ADDR_PP_MODE, 32'hbc);
        pulse_pp(1'b0);
        wr(ADDR_PP_MODE, 32'hba);
        pulse_pp(1'b1);
        wr(ADDR_PP_MODE, 32'h3a);
        pulse_pp(1'b0);
        $display("test parallel port done");
        for (int s = 0; s < 2; s++) begin
            v = 8'($urandom);
            b = 8'($urandom);
            wr(ADDR_U1_MODE, {24'h0, s[0], 5'h0, v[1:0]});
            wr(ADDR_U2_MODE, {24'h0, b});
            `CHK({uart_high_speed, uart_midi_enable}, {b[1], v[1], b[0], v[0]})
            repeat (8) begin
                @(posedge pclk);
                uart_irq_request <= 2'($urandom);
                @(posedge pclk);
                @(negedge pclk);
                `CHK(uart_irq_out, exp_uart(uart_irq_request, s[0]))
            end
        end
        $display("test uart done");
        for (int k = 0; k < 4; k++) begin
            v = {1'b0, k[1], 3'(k), 1'b0, 2'($urandom)};
            wr(ADDR_IR_OPTION, {24'h0, v});
            `CHK({ir_mode, ir_half_duplex}, {v[5:3], 1'b0})
            d = 1'($urandom);
            @(posedge pclk);
            ir_tx_data <= d;
            second_uart_receive_pin <= d;
            alt_infrared_receive_pin <= ~d;
            repeat (5) @(negedge pclk);
            b[1:0] = v[6] ? {~v[1], d ^ v[1]} : {d ^ v[1], ~v[1]};
            `CHK({second_uart_transmit_pin, alt_infrared_transmit_pin}, b[1:0])
            `CHK(ir_rx_data, (v[6] ? ~d : d) ^ v[0])
        end
        $display("test infrared pins done");
        wr(ADDR_IR_OPTION, 32'h04);
        wr(ADDR_IR_TIMEOUT, 32'h01);
        wr(ADDR_EV_MASK, 32'h3);
        @(posedge pclk);
        second_uart_receive_pin <= 1'b1;
        ir_tx_busy <= 1'b1;
        repeat (6) @(negedge pclk);
        wr(ADDR_EV_STATUS, 32'h3);
        @(negedge pclk);
        `CHK({ir_half_duplex, irq, ir_rx_data}, 3'b100)
        @(posedge pclk);
        ir_tx_busy <= 1'b0;
        repeat (STEP_CYCLES - 100) @(negedge pclk);
        `CHK(ir_rx_data, 1'b0)
        repeat (200) @(negedge pclk);
        `CHK({irq, ir_rx_data}, 2'b11)
        rd_chk(ADDR_EV_STATUS, 32'h1);
        wr(ADDR_EV_MASK, 32'h0);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        wr(ADDR_EV_MASK, 32'h1);
        @(negedge pclk);
        `CHK(irq, 1'b1)
        wr(ADDR_EV_STATUS, 32'h1);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        rd_chk(ADDR_EV_STATUS, 32'h0);
        $display("test blanking and events done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check_resets();
        $display("test second reset done");
        report_and_stop();
    end
endmodule
